// *** core/system_watchdog_timer.sv ***
// watchdog timer with sleep wake, status flags and register port
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "wd_regs.svh"

module system_watchdog_timer #(
  parameter int LF_PER_TICK = `WD_LF_PER_TICK,
  parameter int CNT_W = `WD_CNT_W
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_low_freq_internal_osc,
  input wire wd_pkg::wd_mode_e i_wd_mode_config,
  input wire logic i_sleep,
  input wire logic i_idle,
  input wire logic i_wd_clear_instr,
  input wire logic i_osc_fail,
  input wire logic i_osc_startup_timer,
  input wire logic [`WD_ADDR_W-1:0] i_addr,
  input wire logic [`WD_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [`WD_DATA_W-1:0] o_rdata,
  output logic o_wd_reset,
  output logic o_wake,
  output logic o_timeout_flag_n,
  output logic o_powerdown_flag_n,
  output logic o_irq
);
  import wd_pkg::*;

  // period = 2^ps ms; codes above the top one saturate at 2^18 ms, about 262 s
  function automatic logic [CNT_W-1:0] period_last(input logic [4:0] ps);
    logic [4:0] e;
    e = (ps > `WD_PS_MAX) ? `WD_PS_MAX : ps;
    return (CNT_W'(1) << e) - CNT_W'(1);
  endfunction

  logic base_tick;
  logic [4:0] timeout_period_select_reg;
  logic sw_wd_enable_reg;
  logic [`WD_EV_COUNT-1:0] status_reg;
  logic [`WD_EV_COUNT-1:0] status_next;
  logic [`WD_EV_COUNT-1:0] mask_reg;
  logic [`WD_EV_COUNT-1:0] event_set;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  wd_state_e state_reg;
  wd_state_e state_next;
  logic lp_reg;
  logic low_power;
  logic lp_entry;
  logic lp_exit;
  logic mode_on;
  logic expire;
  logic clear_cnt;
  logic clear_evt;
  logic hit_last;
  logic sel_control;
  logic sel_status;
  logic sel_mask;
  logic sel_flags;
  logic wr_control;
  logic wr_status;
  logic wr_mask;
  logic [`WD_DATA_W-1:0] rd_mux;
  logic [`WD_DATA_W-1:0] control_view;
  logic [`WD_DATA_W-1:0] flags_view;
  logic to_n_next;
  logic pd_n_next;

  lf_timebase #(
    .DIV(LF_PER_TICK)
  ) u_timebase (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_low_freq_internal_osc(i_low_freq_internal_osc),
    .o_base_tick(base_tick)
  );

  // register decode
  assign sel_control = (i_addr == `WD_OFS_CONTROL);
  assign sel_status = (i_addr == `WD_OFS_STATUS);
  assign sel_mask = (i_addr == `WD_OFS_MASK);
  assign sel_flags = (i_addr == `WD_OFS_FLAGS);
  assign wr_control = i_wr & sel_control;
  assign wr_status = i_wr & sel_status;
  assign wr_mask = i_wr & sel_mask;

  assign control_view = {2'h0, timeout_period_select_reg, sw_wd_enable_reg};
  assign flags_view = {4'h0, (state_reg == ST_RUN), low_power,
                       o_powerdown_flag_n, o_timeout_flag_n};
  assign rd_mux = sel_control ? control_view :
                  sel_status ? {6'h0, status_reg} :
                  sel_mask ? {6'h0, mask_reg} :
                  sel_flags ? flags_view : '0;

  // idle counts as low power so a time-out there only wakes
  assign low_power = i_sleep | i_idle;
  assign lp_entry = low_power & ~lp_reg;
  assign lp_exit = ~low_power & lp_reg;

  // operating mode table
  assign mode_on = (i_wd_mode_config == MODE_ALWAYS) |
                   ((i_wd_mode_config == MODE_NO_SLEEP) & ~i_sleep) |
                   ((i_wd_mode_config == MODE_SW) & sw_wd_enable_reg);

  // a clear in the same cycle as the last tick beats the time-out
  assign clear_evt = i_wd_clear_instr | lp_entry | lp_exit |
                     i_osc_fail | i_osc_startup_timer;
  // at or past the end: a shorter period written mid-count still fires
  assign hit_last = (cnt_reg >= period_last(timeout_period_select_reg));
  // a watchdog turned off in the last cycle must not fire
  assign expire = mode_on & (state_reg == ST_RUN) & base_tick & hit_last &
                  ~clear_evt;
  assign clear_cnt = ~mode_on | clear_evt | (state_reg != ST_RUN) |
                     expire;
  // no clock switch input exists: the count only sees its own tick
  assign cnt_next = clear_cnt ? '0 :
                    (base_tick ? cnt_reg + CNT_W'(1) : cnt_reg);

  always_comb begin
    state_next = state_reg;
    if (!mode_on) begin
      state_next = ST_DISABLED;
    end else if (lp_exit) begin
      state_next = ST_HOLD;
    end else begin
      case (state_reg)
        ST_DISABLED: state_next = ST_RUN;
        ST_RUN: state_next = ST_RUN;
        ST_HOLD: state_next = i_osc_startup_timer ? ST_HOLD : ST_RUN;
        default: state_next = ST_DISABLED;
      endcase
    end
  end

  // sticky events, set wins over a write-one clear
  assign event_set[`WD_EV_RESET_BIT] = expire & ~low_power;
  assign event_set[`WD_EV_WAKE_BIT] = expire & low_power;
  genvar g;
  generate
    for (g = 0; g < `WD_EV_COUNT; g = g + 1) begin : g_status
      assign status_next[g] = event_set[g] |
                              (status_reg[g] & ~(wr_status & i_wdata[g]));
    end
  endgenerate

  assign to_n_next = expire ? 1'b0 :
                     (i_wd_clear_instr ? 1'b1 : o_timeout_flag_n);
  assign pd_n_next = (lp_entry | expire) ? 1'b0 :
                     (i_wd_clear_instr ? 1'b1 : o_powerdown_flag_n);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      timeout_period_select_reg <= `WD_PS_RESET;
      sw_wd_enable_reg <= `WD_SWEN_RESET;
      mask_reg <= `WD_MASK_RESET;
    end else if (wr_control) begin
      timeout_period_select_reg <= i_wdata[`WD_CTL_PS_MSB:`WD_CTL_PS_LSB];
      sw_wd_enable_reg <= i_wdata[`WD_CTL_SWEN_BIT];
    end else if (wr_mask) begin
      mask_reg <= i_wdata[`WD_EV_COUNT-1:0];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
      state_reg <= ST_DISABLED;
      lp_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      state_reg <= state_next;
      lp_reg <= low_power;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_wd_reset <= 1'b0;
      o_wake <= 1'b0;
      o_timeout_flag_n <= 1'b1;
      o_powerdown_flag_n <= 1'b1;
    end else begin
      o_wd_reset <= expire & ~low_power;
      o_wake <= expire & low_power;
      o_timeout_flag_n <= to_n_next;
      o_powerdown_flag_n <= pd_n_next;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      status_reg <= '0;
      o_irq <= 1'b0;
      o_rdata <= '0;
    end else begin
      status_reg <= status_next;
      o_irq <= |(status_next & mask_reg);
      o_rdata <= i_rd ? rd_mux : '0;
    end
  end

  // checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence awake_expiry;
    expire && !low_power;
  endsequence

  sequence asleep_expiry;
    expire && low_power;
  endsequence

  timeout_reset_a: assert property (
    awake_expiry |=> o_wd_reset && !o_wake ##1 !o_wd_reset)
    else $error("awake time-out did not give one reset pulse");

  sleep_wake_a: assert property (
    asleep_expiry |=> o_wake && !o_wd_reset ##1 !o_wake)
    else $error("sleep time-out did not wake cleanly");

  count_step_a: assert property (
    (state_reg == ST_RUN && base_tick && !clear_cnt) |=>
      cnt_reg == $past(cnt_reg) + CNT_W'(1))
    else $error("counter did not step on the base tick");

  mode_off_a: assert property (
    (i_wd_mode_config == MODE_OFF) |=> cnt_reg == '0 && !o_wd_reset)
    else $error("counter not held clear with watchdog off");

  mode_sleep_off_a: assert property (
    (i_wd_mode_config == MODE_NO_SLEEP && i_sleep) |=>
      cnt_reg == '0 && state_reg == ST_DISABLED)
    else $error("watchdog ran in sleep in awake-only mode");

  always_on_a: assert property (
    (i_wd_mode_config == MODE_ALWAYS && state_reg == ST_RUN &&
     !lp_exit) |=> state_reg == ST_RUN)
    else $error("always-on watchdog left the run state");

  sw_mode_a: assert property (
    (i_wd_mode_config == MODE_SW && !sw_wd_enable_reg) |=>
      state_reg == ST_DISABLED)
    else $error("software mode ran with enable low");

  clear_instr_a: assert property (
    (i_wd_clear_instr || lp_entry) |=> cnt_reg == '0 && !o_wd_reset)
    else $error("clear event did not clear the counter");

  startup_hold_a: assert property (
    (lp_exit && mode_on) ##1 i_osc_startup_timer [*2] |=>
      cnt_reg == '0 && state_reg == ST_HOLD)
    else $error("counter moved while start-up timer ran");

  flag_update_a: assert property (
    expire |=> !o_timeout_flag_n && !o_powerdown_flag_n)
    else $error("time-out did not update status flags");

  period_default_a: assert property (
    (i_rst_n && !$past(i_rst_n)) |->
      timeout_period_select_reg == `WD_PS_RESET)
    else $error("period field not at default after reset");

  idle_wake_a: assert property (
    (expire && i_idle) |=> o_wake && !o_wd_reset)
    else $error("idle time-out did not wake");

  osc_fail_clear_a: assert property (
    i_osc_fail |=> cnt_reg == '0)
    else $error("oscillator failure did not clear counter");

  startup_clear_a: assert property (
    i_osc_startup_timer |=> cnt_reg == '0)
    else $error("counter moved while start-up timer ran");

  sleep_resume_a: assert property (
    (lp_entry && state_reg == ST_RUN && i_wd_mode_config == MODE_ALWAYS)
      |=> cnt_reg == '0 && state_reg == ST_RUN)
    else $error("counter did not restart on sleep entry");

  clear_flags_a: assert property (
    (i_wd_clear_instr && !lp_entry) |=>
      o_timeout_flag_n && o_powerdown_flag_n)
    else $error("clear instruction did not restore flags");

  pd_entry_a: assert property (
    lp_entry |=> !o_powerdown_flag_n)
    else $error("power-down flag not set on low power entry");

  expiry_restart_a: assert property (
    expire |=> cnt_reg == '0)
    else $error("counter did not restart after time-out");

  hold_quiet_a: assert property (
    (state_reg == ST_HOLD) |=> !o_wd_reset && !o_wake)
    else $error("time-out while held after wake-up");

  wake_clear_a: assert property (
    lp_exit |=> cnt_reg == '0)
    else $error("wake-up did not clear counter");

  disabled_quiet_a: assert property (
    (state_reg == ST_DISABLED) |-> cnt_reg == '0)
    else $error("counter not clear while disabled");

  rdata_idle_a: assert property (
    !i_rd |=> o_rdata == '0)
    else $error("read data without a read");

  rdata_ctl_a: assert property (
    (i_rd && sel_control) |=> o_rdata[7:6] == 2'h0)
    else $error("unused control bits read non-zero");

  irq_clear_a: assert property (
    (!(|event_set) && (status_reg & mask_reg) == '0) |=> !o_irq)
    else $error("interrupt high with nothing pending");

  set_wins_a: assert property (
    (|event_set) |=> (status_reg & $past(event_set)) == $past(event_set))
    else $error("status event lost to a clear");

endmodule

// *** core/wd_regs.svh ***
// register map, field positions, reset values and timing counts
`ifndef WD_REGS_SVH
`define WD_REGS_SVH

`define WD_ADDR_W 4
`define WD_DATA_W 8

`define WD_OFS_CONTROL 4'h0
`define WD_OFS_STATUS 4'h1
`define WD_OFS_MASK 4'h2
`define WD_OFS_FLAGS 4'h3

`define WD_CTL_SWEN_BIT 0
`define WD_CTL_PS_LSB 1
`define WD_CTL_PS_MSB 5

`define WD_EV_RESET_BIT 0
`define WD_EV_WAKE_BIT 1
`define WD_EV_COUNT 2

`define WD_FLG_TO_N_BIT 0
`define WD_FLG_PD_N_BIT 1
`define WD_FLG_LP_BIT 2
`define WD_FLG_RUN_BIT 3

`define WD_PS_RESET 5'h0b
`define WD_PS_MAX 5'h12
`define WD_SWEN_RESET 1'b0
`define WD_MASK_RESET 2'h0

`define WD_LF_OSC_HZ 31000
`define WD_BASE_TICK_US 1000
`define WD_LF_PER_TICK ((`WD_LF_OSC_HZ * `WD_BASE_TICK_US) / 1000000)
`define WD_CNT_W 19

`endif

// *** core/wd_pkg.sv ***
// types shared by the watchdog timer and its testbench
package wd_pkg;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_SW = 2'h1,
    MODE_NO_SLEEP = 2'h2,
    MODE_ALWAYS = 2'h3
  } wd_mode_e;

  typedef enum logic [2:0] {
    ST_DISABLED = 3'h1,
    ST_RUN = 3'h2,
    ST_HOLD = 3'h4
  } wd_state_e;

endpackage

// *** core/lf_timebase.sv ***
// base tick generator fed by the low frequency oscillator pin
`timescale 1ns/10ps
`include "wd_regs.svh"

module lf_timebase #(
  parameter int DIV = `WD_LF_PER_TICK
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_low_freq_internal_osc,
  output logic o_base_tick
);
  localparam int DW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);

  logic osc_meta_reg;
  logic osc_sync_reg;
  logic osc_prev_reg;
  logic [DW-1:0] div_reg;
  logic [DW-1:0] div_next;
  logic osc_edge;
  logic tick_next;

  // the oscillator is asynchronous; only rising edges are counted
  assign osc_edge = osc_sync_reg & ~osc_prev_reg;
  assign tick_next = osc_edge & (div_reg == DIV_LAST);
  assign div_next = tick_next ? '0 : (osc_edge ? div_reg + 1'b1 : div_reg);

  always_ff @(posedge i_sys_clk) begin
    osc_meta_reg <= i_low_freq_internal_osc;
    osc_sync_reg <= osc_meta_reg;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      // track the pin level in reset so release gives no false edge
      osc_prev_reg <= osc_sync_reg;
      div_reg <= '0;
      o_base_tick <= 1'b0;
    end else begin
      osc_prev_reg <= osc_sync_reg;
      div_reg <= div_next;
      o_base_tick <= tick_next;
    end
  end

  tick_one_cycle_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n) o_base_tick |=> !o_base_tick)
    else $error("base tick longer than one cycle");

endmodule

// *** verification/core_side_model.sv ***
// partner model: low frequency oscillator and core clear pulses
`timescale 1ns/10ps

module core_side_model #(
  parameter int HALF = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_clr_on,
  input wire logic [7:0] i_clr_gap,
  output logic o_low_freq_internal_osc,
  output logic o_wd_clear_instr
);
  int osc_cnt;
  int gap_cnt;

  initial begin
    o_low_freq_internal_osc = 1'b0;
    o_wd_clear_instr = 1'b0;
    osc_cnt = 0;
    gap_cnt = 0;
  end

  // runs free: the oscillator never stops for the watchdog
  always @(posedge i_sys_clk) begin
    osc_cnt <= (osc_cnt == HALF - 1) ? 0 : osc_cnt + 1;
    if (osc_cnt == HALF - 1) begin
      o_low_freq_internal_osc <= ~o_low_freq_internal_osc;
    end
  end

  // one-cycle pulses, never two in a row unless i_clr_gap is zero
  always @(posedge i_sys_clk) begin
    gap_cnt <= (!i_clr_on || gap_cnt == int'(i_clr_gap)) ? 0 : gap_cnt + 1;
    o_wd_clear_instr <= i_clr_on && gap_cnt == int'(i_clr_gap);
  end
endmodule

// *** verification/test_system_watchdog_timer.sv ***
// self-checking bench for the watchdog timer
`timescale 1ns/10ps
`include "wd_regs.svh"

module test_system_watchdog_timer;
  import wd_pkg::*;
  logic i_sys_clk, i_rst_n, osc, clr, clr_on, i_wr, i_rd;
  logic i_sleep, i_idle, i_osc_fail, i_osc_startup_timer;
  logic o_wd_reset, o_wake, o_timeout_flag_n, o_powerdown_flag_n, o_irq;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata, rd, gap;
  wd_mode_e mode;
  int failures, checks_done, cycles, rst_cnt, wake_cnt;

  system_watchdog_timer #(.LF_PER_TICK(2)) system_watchdog_timer_i (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_low_freq_internal_osc(osc), .i_wd_mode_config(mode),
    .i_sleep(i_sleep), .i_idle(i_idle), .i_wd_clear_instr(clr),
    .i_osc_fail(i_osc_fail), .i_osc_startup_timer(i_osc_startup_timer),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_wd_reset(o_wd_reset), .o_wake(o_wake),
    .o_timeout_flag_n(o_timeout_flag_n),
    .o_powerdown_flag_n(o_powerdown_flag_n), .o_irq(o_irq)
  );

  core_side_model core_side_model_i (
    .i_sys_clk(i_sys_clk), .i_clr_on(clr_on), .i_clr_gap(gap),
    .o_low_freq_internal_osc(osc), .o_wd_clear_instr(clr)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  task automatic stop_test();
    $display("failures=%0d checks_done=%0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ceiling well above the ~3500 cycles the sequence needs
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (o_wd_reset === 1'b1) rst_cnt <= rst_cnt + 1;
    if (o_wake === 1'b1) wake_cnt <= wake_cnt + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      $display("BAD %0t run hung", $time);
      stop_test();
    end
  end

  task automatic fail_if(input logic bad, input string what);
    checks_done = checks_done + 1;
    if (bad) begin
      failures = failures + 1;
      $display("BAD %0t %s", $time, what);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask

  task automatic chk_reg(input logic [3:0] a, input logic [7:0] m,
                         input logic [7:0] e);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 rd = o_rdata;
    fail_if((rd & m) !== e, $sformatf("reg %h read %h", a, rd));
  endtask

  task automatic chk_bit(input logic got, input logic e);
    fail_if(got !== e, "output level wrong");
  endtask

  task automatic chk_cnt(input int got, input int e);
    fail_if((got > 0 ? 1 : 0) != e, $sformatf("event count %0d", got));
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic restart(input wd_mode_e m);
    @(posedge i_sys_clk);
    i_rst_n <= 1'b0;
    mode <= m;
    {i_osc_startup_timer, i_osc_fail, i_idle, i_sleep} <= 4'h0;
    repeat (10) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
  endtask

  // lv = {start-up timer, osc fail, idle, sleep}
  task automatic run(input wd_mode_e m, input logic [7:0] ctl,
                     input logic [3:0] lv, input int n, input int er,
                     input int ew);
    restart(m);
    wr(`WD_OFS_CONTROL, ctl);
    @(posedge i_sys_clk);
    {i_osc_startup_timer, i_osc_fail, i_idle, i_sleep} <= lv;
    #1 rst_cnt = 0;
    wake_cnt = 0;
    wait_n(n);
    chk_cnt(rst_cnt, er);
    chk_cnt(wake_cnt, ew);
  endtask

  initial begin
    {i_rst_n, i_wr, i_rd, clr_on} = 4'h0;
    {i_sleep, i_idle, i_osc_fail, i_osc_startup_timer} = 4'h0;
    {i_addr, i_wdata, gap} = 20'h0;
    mode = MODE_ALWAYS;
    {failures, checks_done, cycles, rst_cnt, wake_cnt} = '0;
    restart(MODE_ALWAYS);
    chk_reg(`WD_OFS_CONTROL, 8'hff, 8'h16);
    chk_reg(`WD_OFS_STATUS, 8'hff, 8'h00);
    chk_reg(`WD_OFS_MASK, 8'hff, 8'h00);
    chk_reg(`WD_OFS_FLAGS, 8'h07, 8'h03);
    chk_reg(4'h9, 8'hff, 8'h00);
    // period: quiet before 2^ps ticks of 16 clocks, fires soon after
    for (int ps = 0; ps <= 4; ps += 2) begin
      run(MODE_ALWAYS, 8'(ps << 1), 4'h0, ((1 << ps) - 1) * 16, 0, 0);
      wait_n(56);
      chk_cnt(rst_cnt, 1);
    end
    chk_reg(`WD_OFS_FLAGS, 8'h03, 8'h00);
    chk_reg(`WD_OFS_STATUS, 8'h03, 8'h01);
    wr(`WD_OFS_MASK, 8'h01);
    wait_n(1);
    chk_bit(o_irq, 1'b1);
    wr(`WD_OFS_STATUS, 8'h01);
    wait_n(1);
    chk_bit(o_irq, 1'b0);
    gap <= 8'd20;
    clr_on <= 1'b1;
    run(MODE_ALWAYS, 8'h04, 4'h0, 300, 0, 0);
    clr_on <= 1'b0;
    wait_n(120);
    chk_cnt(rst_cnt, 1);
    clr_on <= 1'b1;
    wait_n(30);
    chk_bit(o_timeout_flag_n, 1'b1);
    clr_on <= 1'b0;
    run(MODE_ALWAYS, 8'h04, 4'h1, 120, 0, 1);
    chk_bit(o_powerdown_flag_n, 1'b0);
    run(MODE_NO_SLEEP, 8'h04, 4'h1, 300, 0, 0);
    run(MODE_NO_SLEEP, 8'h04, 4'h0, 120, 1, 0);
    run(MODE_NO_SLEEP, 8'h04, 4'h2, 120, 0, 1);
    run(MODE_SW, 8'h04, 4'h0, 300, 0, 0);
    run(MODE_SW, 8'h05, 4'h1, 120, 0, 1);
    run(MODE_SW, 8'h05, 4'h0, 120, 1, 0);
    run(MODE_OFF, 8'h05, 4'h0, 300, 0, 0);
    run(MODE_ALWAYS, 8'h04, 4'h4, 300, 0, 0);
    run(MODE_ALWAYS, 8'h04, 4'h9, 300, 0, 0);
    run(MODE_ALWAYS, 8'h04, 4'h1, 30, 0, 0);
    @(posedge i_sys_clk);
    {i_osc_startup_timer, i_osc_fail, i_idle, i_sleep} <= 4'h8;
    wait_n(150);
    chk_cnt(rst_cnt, 0);
    chk_reg(`WD_OFS_FLAGS, 8'h0c, 8'h00);
    @(posedge i_sys_clk);
    i_osc_startup_timer <= 1'b0;
    wait_n(120);
    chk_cnt(rst_cnt, 1);
    stop_test();
  end
endmodule
